// >>> src/efw_pkg.sv
// ==========================================================================
// Shared constants for the flash word writer
package efw_pkg;

  // ========================================================================
  // Clock and timing
  localparam int CLK_MHZ = 40;
  localparam int T_PROG_US = 20;              // One word programming time
  localparam int T_TMO_US = 40;               // Longest wait for a byte pair
  localparam int T_ERASE_PAGE_MS = 20;        // One page erase time
  localparam int T_ERASE_CHIP_MS = 200;       // Whole array erase time
  localparam int PROG_CYC = T_PROG_US * CLK_MHZ;
  localparam int TMO_CYC = T_TMO_US * CLK_MHZ;
  localparam int ERASE_PAGE_CYC_DEF = T_ERASE_PAGE_MS * 1000 * CLK_MHZ;
  localparam int ERASE_CHIP_CYC_DEF = T_ERASE_CHIP_MS * 1000 * CLK_MHZ;

  // ========================================================================
  // Array geometry
  localparam int WORDS_PER_PAGE = 512;
  localparam int WADDR_W = 14;
  localparam int PAGES_MAX = 32;

  // ========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;    // nvm_control_register
  localparam logic [7:0] OFS_ADDRH = 8'h04;   // nvm_address_high
  localparam logic [7:0] OFS_ADDRL = 8'h08;   // nvm_address_low
  localparam logic [7:0] OFS_WDATA = 8'h0C;   // nvm_write_data_register

  // ========================================================================
  // Control register field positions
  localparam int BIT_ERASE = 0;
  localparam int BIT_START = 1;               // program_start_bit
  localparam int BIT_CHIP = 2;
  localparam int BIT_PEND = 6;                // word_write_pending_flag
  localparam int BIT_ACTIVE = 7;              // operation_active_flag

  // ========================================================================
  // Reset values
  localparam logic [5:0] ADDRH_RST = 6'h00;
  localparam logic [7:0] ADDRL_RST = 8'h00;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // ========================================================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ERASE,
    ST_WAIT,
    ST_PROG
  } efw_state_t;

endpackage

// >>> src/efw_array.sv
`timescale 1ns/1ps
// ==========================================================================
// Word array: programming only clears bits, erase sets a word to all ones
module efw_array
  import efw_pkg::*;
#(
  parameter int DEPTH = PAGES_MAX * WORDS_PER_PAGE,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic ref_clk,
  input wire logic prog_en,
  input wire logic [AW-1:0] prog_idx,
  input wire logic [15:0] prog_data,
  input wire logic erase_en,
  input wire logic [AW-1:0] erase_idx,
  input wire logic [AW-1:0] rd_idx,
  output logic [15:0] rd_data_q
);

  logic [15:0] mem [DEPTH];

  // Erase wins over programming; a program is an AND with the stored word
  always_ff @(posedge ref_clk) begin
    if (erase_en) begin
      mem[erase_idx] <= ERASED_WORD;
    end else if (prog_en) begin
      mem[prog_idx] <= mem[prog_idx] & prog_data;
    end
  end

  // Registered read port for the CPU
  always_ff @(posedge ref_clk) begin
    rd_data_q <= mem[rd_idx];
  end

endmodule

// >>> src/efw_writer.sv
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
// ==========================================================================
// Notes on behaviour
// - Writing one to the start bit begins a write at the stored word address.
// - Programming only clears bits; a one over a zero is ignored.
// - Erase sets every erased bit to one; nothing else restores ones.
// - Pending flag is high during each single word programming, then low.
// - First byte after a word boundary is the low byte, second the high.
// - One word programmed per two bytes; software supplies an even count.
// - Writes address the array by a 14-bit word address from both registers.
// - High bits five to one pick the page; the rest pick the word.
// - Array holds 8, 16 or 32 pages of 1024 bytes; word is writable unit.
// - CPU array accesses, fetches included, are blocked while a word programs.
// - Setting the start bit never stalls the bus; the CPU proceeds at once.
// - Array access while pending is a violation; software waits first.
// - DMA trigger fires whenever the write data register can take data.
// - Setting the start bit alone issues the first DMA trigger; with an erase bit set, the end of the erase issues it.
// - Word program 20 us, page erase 20 ms, whole erase 200 ms.
// - Page erase selects the page only by high bits five to one.
// - Each byte pair must come within 40 us, else the sequence aborts.
// - On timeout the active flag clears; address stays at the failed word.
// - Active flag reads one while any write or erase is underway.
module efw_writer
  import efw_pkg::*;
#(
  parameter int NUM_PAGES = PAGES_MAX,
  parameter int ERASE_CYC = ERASE_PAGE_CYC_DEF,
  parameter int CHIP_CYC = ERASE_CHIP_CYC_DEF
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic cpu_req,
  input wire logic [14:0] cpu_addr,
  output logic [15:0] cpu_rdata,
  output logic cpu_rvalid,
  output logic cpu_stall,
  output logic cpu_violation,
  output logic dma_trigger
);

  // Array depth and counter reloads; counters stop at zero, except a low byte taken at zero wraps the timer
  localparam int DEPTH = NUM_PAGES * WORDS_PER_PAGE;
  localparam int AW = $clog2(DEPTH);
  localparam logic [31:0] PROG_LOAD = 32'(PROG_CYC - 1);
  localparam logic [31:0] TMO_LOAD = 32'(TMO_CYC - 1);
  localparam logic [31:0] ERASE_LOAD = 32'(ERASE_CYC - 1);
  localparam logic [31:0] CHIP_LOAD = 32'(CHIP_CYC - 1);
  // Erase spans in words: one page, or the whole fitted array
  localparam logic [14:0] PAGE_WORDS = 15'(WORDS_PER_PAGE);
  localparam logic [14:0] ALL_WORDS = 15'(DEPTH);

  // ========================================================================
  // Helpers
  // Folds a 14-bit word address onto the fitted array depth
  function automatic logic [AW-1:0] to_idx(input logic [WADDR_W-1:0] wa);
    to_idx = wa[AW-1:0];
  endfunction

  // Matches a bus address against one register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ========================================================================
  // State
  // Sequencer and bus interface registers
  efw_state_t state_q;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  // Word address and the byte pair being assembled
  logic [5:0] addr_hi_q;
  logic [7:0] addr_lo_q;
  logic [31:0] tm_q;
  logic byte_sel_q;
  logic [7:0] lsb_q;
  logic [15:0] word_q;
  logic pend_q;
  logic wr_after_q;
  logic [AW-1:0] erase_idx_q;
  logic [14:0] erase_left_q;
  // Registered port outputs
  logic dma_trigger_select_q;
  logic rvalid_q;
  logic stall_q;
  logic viol_q;

  // Decoded strobes and sequencer events
  logic acc;
  logic wr_acc;
  logic mapped;
  logic wr_ctrl;
  logic wr_data;
  logic go_write;
  logic go_erase;
  logic go_chip;
  logic prog_done;
  logic erase_en;
  logic blocked;
  logic dma_trigger_select_d;
  logic [WADDR_W-1:0] word_addr;
  logic [15:0] rd_word;

  // ========================================================================
  // Bus decode
  assign acc = psel & penable & pready_q;
  assign wr_acc = acc & pwrite;
  assign mapped = hit(paddr, OFS_CTRL) | hit(paddr, OFS_ADDRH) |
                  hit(paddr, OFS_ADDRL) | hit(paddr, OFS_WDATA);
  assign wr_ctrl = wr_acc & hit(paddr, OFS_CTRL) & (state_q == ST_IDLE);
  assign wr_data = wr_acc & hit(paddr, OFS_WDATA) & (state_q == ST_WAIT);
  assign go_write = wr_ctrl & pwdata[BIT_START];
  assign go_erase = wr_ctrl & pwdata[BIT_ERASE];
  assign go_chip = wr_ctrl & pwdata[BIT_CHIP] & ~pwdata[BIT_ERASE];
  assign word_addr = {addr_hi_q, addr_lo_q};
  assign prog_done = (state_q == ST_PROG) && (tm_q == 32'h0000_0000);
  assign erase_en = (state_q == ST_ERASE) && (erase_left_q != 15'h0000);
  assign blocked = pend_q | (state_q == ST_ERASE);

  // ========================================================================
  // APB slave: one wait-free access phase, error on unmapped offsets
  // The start bit is taken like any write, so the bus never stalls
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel & ~penable & ~pready_q;
      pslverr_q <= psel & ~penable & ~pready_q & ~mapped;
    end
  end

  // Read data, loaded in the setup cycle; write-only data reads as zero
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel & ~penable & ~pready_q & ~pwrite) begin
      case (paddr)
        OFS_CTRL: begin
          prdata_q <= 32'h0000_0000;
          prdata_q[BIT_ACTIVE] <= (state_q != ST_IDLE);
          prdata_q[BIT_PEND] <= pend_q;
        end
        OFS_ADDRH: prdata_q <= {26'h000_0000, addr_hi_q};
        OFS_ADDRL: prdata_q <= {24'h00_0000, addr_lo_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ========================================================================
  // Address registers: software writes them while idle, hardware steps them
  // A timeout leaves them on the word that was never programmed
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      addr_hi_q <= ADDRH_RST;
      addr_lo_q <= ADDRL_RST;
    end else if (prog_done) begin
      {addr_hi_q, addr_lo_q} <= word_addr + 14'h0001;
    end else if (wr_acc && (state_q == ST_IDLE)) begin
      if (hit(paddr, OFS_ADDRH)) begin
        addr_hi_q <= pwdata[5:0];
      end
      if (hit(paddr, OFS_ADDRL)) begin
        addr_lo_q <= pwdata[7:0];
      end
    end
  end

  // ========================================================================
  // Sequencer: erase, then wait for byte pairs, then program each word
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      tm_q <= 32'h0000_0000;
      byte_sel_q <= 1'b0;
      lsb_q <= 8'h00;
      word_q <= ERASED_WORD;
      pend_q <= 1'b0;
      wr_after_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          byte_sel_q <= 1'b0;
          wr_after_q <= go_write;
          if (go_erase) begin
            state_q <= ST_ERASE;
            tm_q <= ERASE_LOAD;
          end else if (go_chip) begin
            state_q <= ST_ERASE;
            tm_q <= CHIP_LOAD;
          end else if (go_write) begin
            state_q <= ST_WAIT;
            tm_q <= TMO_LOAD;
          end
        end
        ST_ERASE: begin
          // Done only when the timer and the word walk have both run out
          if ((tm_q == 32'h0000_0000) && (erase_left_q == 15'h0000)) begin
            state_q <= wr_after_q ? ST_WAIT : ST_IDLE;
            tm_q <= TMO_LOAD;
          end else if (tm_q != 32'h0000_0000) begin
            tm_q <= tm_q - 32'h0000_0001;
          end
        end
        ST_WAIT: begin
          if (wr_data && !byte_sel_q) begin
            lsb_q <= pwdata[7:0];
            byte_sel_q <= 1'b1;
            tm_q <= tm_q - 32'h0000_0001;
          end else if (wr_data) begin
            word_q <= {pwdata[7:0], lsb_q};
            byte_sel_q <= 1'b0;
            pend_q <= 1'b1;
            state_q <= ST_PROG;
            tm_q <= PROG_LOAD;
          // Timeout: a held low byte is dropped, the address stays put
          end else if (tm_q == 32'h0000_0000) begin
            state_q <= ST_IDLE;
            byte_sel_q <= 1'b0;
          end else begin
            tm_q <= tm_q - 32'h0000_0001;
          end
        end
        ST_PROG: begin
          if (prog_done) begin
            pend_q <= 1'b0;
            state_q <= ST_WAIT;
            tm_q <= TMO_LOAD;
          end else begin
            tm_q <= tm_q - 32'h0000_0001;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          pend_q <= 1'b0;
        end
      endcase
    end
  end

  // ========================================================================
  // Erase walker: sets one word per cycle to all ones over the page or the array
  // The page comes from the high register bits five to one only
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      erase_idx_q <= '0;
      erase_left_q <= 15'h0000;
    end else if (state_q == ST_IDLE) begin
      if (go_erase) begin
        erase_idx_q <= to_idx({addr_hi_q[5:1], 9'h000});
        erase_left_q <= PAGE_WORDS;
      end else if (go_chip) begin
        erase_idx_q <= '0;
        erase_left_q <= ALL_WORDS;
      end
    end else if (erase_en) begin
      erase_idx_q <= erase_idx_q + AW'(1);
      erase_left_q <= erase_left_q - 15'h0001;
    end
  end

  // ========================================================================
  // DMA trigger: a pulse each time the data register opens for a byte
  always_comb begin
    dma_trigger_select_d = 1'b0;
    if ((state_q == ST_IDLE) && go_write && !go_erase &&
        !go_chip) begin
      dma_trigger_select_d = 1'b1;
    end else if ((state_q == ST_ERASE) && wr_after_q && (tm_q == 32'h0000_0000) &&
                 (erase_left_q == 15'h0000)) begin
      dma_trigger_select_d = 1'b1;
    end else if (wr_data && !byte_sel_q) begin
      dma_trigger_select_d = 1'b1;
    end else if (prog_done) begin
      dma_trigger_select_d = 1'b1;
    end
  end

  // Trigger leaves through a flop, one cycle after its event
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      dma_trigger_select_q <= 1'b0;
    end else begin
      dma_trigger_select_q <= dma_trigger_select_d;
    end
  end

  // ========================================================================
  // CPU array port: held off while busy, flagged if a word is pending
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      stall_q <= 1'b0;
      viol_q <= 1'b0;
    end else begin
      rvalid_q <= cpu_req & ~blocked;
      stall_q <= cpu_req & blocked;
      viol_q <= cpu_req & pend_q;
    end
  end

  // ========================================================================
  // Word array
  efw_array #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_array (
    .ref_clk(ref_clk),
    .prog_en(prog_done),
    .prog_idx(to_idx(word_addr)),
    .prog_data(word_q),
    .erase_en(erase_en),
    .erase_idx(erase_idx_q),
    .rd_idx(to_idx(cpu_addr[14:1])),
    .rd_data_q(rd_word)
  );

  // ========================================================================
  // Outputs
  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign cpu_rdata = rd_word;
  assign cpu_rvalid = rvalid_q;
  assign cpu_stall = stall_q;
  assign cpu_violation = viol_q;
  assign dma_trigger = dma_trigger_select_q;

endmodule

// >>> verif/efw_writer_monitor.sv
`timescale 1ns/1ps
// ====
// Port checker for the flash word writer
module efw_writer_monitor
  import efw_pkg::*;
#(
  parameter int NUM_PAGES = PAGES_MAX,
  parameter int ERASE_CYC = ERASE_PAGE_CYC_DEF,
  parameter int CHIP_CYC = ERASE_CHIP_CYC_DEF
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic cpu_req,
  input wire logic [14:0] cpu_addr,
  input wire logic [15:0] cpu_rdata,
  input wire logic cpu_rvalid,
  input wire logic cpu_stall,
  input wire logic cpu_violation,
  input wire logic dma_trigger
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic mapped;
  // Decode of the four register offsets
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_ADDRH) ||
                  (paddr == OFS_ADDRL) || (paddr == OFS_WDATA);
  // ====
  // Bus answers
  bus_answer_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  answer_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  bad_offset_a: assert property (psel && !penable && !mapped |=> pslverr && pready)
    else $error("no error for unmapped offset");
  good_offset_a: assert property (psel && !penable && mapped |=> !pslverr)
    else $error("error on mapped offset");
  // ====
  // Array port and transfer requests
  cpu_answer_a: assert property (cpu_req |=> cpu_rvalid != cpu_stall)
    else $error("cpu request not answered once");
  cpu_quiet_a: assert property (!cpu_req |=> !cpu_rvalid && !cpu_stall && !cpu_violation)
    else $error("cpu answer without request");
  viol_stall_a: assert property (cpu_violation |-> cpu_stall && !cpu_rvalid)
    else $error("violation without stall");
  dma_trigger_select_pulse_a: assert property (dma_trigger |=> !dma_trigger)
    else $error("trigger longer than a cycle");
  cover property (dma_trigger);
  cover property (cpu_violation);
  cover property (pslverr);
endmodule

bind efw_writer efw_writer_monitor #(.NUM_PAGES(NUM_PAGES), .ERASE_CYC(ERASE_CYC),
  .CHIP_CYC(CHIP_CYC)) mon (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
  .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .cpu_stall(cpu_stall),
  .cpu_violation(cpu_violation), .dma_trigger(dma_trigger));

// >>> verif/efw_dma_model.sv
`timescale 1ns/1ps
// ====
// Bus master and byte-feeding transfer channel
module efw_dma_model
  import efw_pkg::*;
(
  input wire logic ref_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic dma_trigger
);
  bit hung;
  // Idle bus at start
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hFF;
    pwdata = 32'h0;
    hung = 1'b0;
  end
  // One transfer; lines show inverted values once released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) hung = 1'b1;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // Waits for the next request for data
  task automatic wait_dma_trigger_select(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (dma_trigger !== 1'b1 && n < lim);
    if (dma_trigger !== 1'b1) hung = 1'b1;
  endtask
  // Single byte transfer, fixed destination; caller forms the pairs, or sends a lone byte
  task automatic put(input logic [7:0] b);
    logic [31:0] q;
    logic e;
    xfer(1'b1, OFS_WDATA, {24'h0, b}, q, e);
  endtask
endmodule

// >>> verif/test_embedded_flash_word_writer.sv
`timescale 1ns/1ps
// ====
// Self-checking bench for the flash word writer
module test_embedded_flash_word_writer;
  import efw_pkg::*;
  logic ref_clk, resetn, cpu_req, psel, penable, pwrite, pready, pslverr;
  logic cpu_rvalid, cpu_stall, cpu_violation, dma_trigger;
  logic [14:0] cpu_addr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] cpu_rdata;
  int failures, comparisons;

  efw_writer #(.ERASE_CYC(600), .CHIP_CYC(17000)) dut (.ref_clk(ref_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .cpu_req(cpu_req),
    .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
    .cpu_stall(cpu_stall), .cpu_violation(cpu_violation), .dma_trigger(dma_trigger));
  efw_dma_model m (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .dma_trigger(dma_trigger));

  // ====
  // Shared tasks
  task check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task stop_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task done(input string name);
    if (m.hung) begin
      failures++;
      stop_test;
    end else begin
      $display("Test %s finished", name);
    end
  endtask
  task rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    m.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    m.xfer(1'b1, a, d, q, e);
  endtask
  // Array read, returns stall, valid and data
  task cpu_rd(input logic [14:0] a, output logic [17:0] r);
    @(posedge ref_clk);
    cpu_req <= 1'b1;
    cpu_addr <= a;
    @(posedge ref_clk);
    cpu_req <= 1'b0;
    @(posedge ref_clk);
    r = {cpu_stall, cpu_rvalid, cpu_rdata};
  endtask
  // Polls until no operation is active
  task wait_idle;
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      rd(OFS_CTRL, q);
      n++;
    end while (q[BIT_ACTIVE] !== 1'b0 && n < 1000);
    if (q[BIT_ACTIVE] !== 1'b0) begin
      failures++;
      stop_test;
    end
  endtask

  // ====
  // Scenarios
  task test_reset;
    logic [31:0] q;
    logic e;
    rd(OFS_CTRL, q);
    check("ctrl", 32'h0, q);
    rd(OFS_ADDRH, q);
    check("addrh", 32'h0, q);
    m.xfer(1'b0, 8'h10, 32'h0, q, e);
    check("slverr", 32'h1, {31'h0, e});
    done("reset");
  endtask
  // Erase with start, two words by transfer channel, end by timeout
  task test_dma_write;
    logic [31:0] q;
    logic [17:0] r;
    int n;
    wr(OFS_ADDRH, 32'h3);
    wr(OFS_ADDRL, 32'hFE);
    wr(OFS_CTRL, 32'h3);
    cpu_req <= 1'b1;
    cpu_addr <= 15'h7FC;
    rd(OFS_CTRL, q);
    check("active", 32'h1, q[BIT_ACTIVE]);
    check("erase stall", 32'h1, cpu_stall);
    m.wait_dma_trigger_select(2000);
    for (int k = 0; k < 2; k++) begin
      m.put(k ? 8'h78 : 8'h34);
      m.wait_dma_trigger_select(10);
      m.put(k ? 8'h56 : 8'h12);
      n = 0;
      for (int i = 0; i < 2000; i++) begin
        @(posedge ref_clk);
        n += int'(cpu_violation);
        if (dma_trigger === 1'b1) break;
      end
      check("pending cycles", PROG_CYC, n);
    end
    cpu_req <= 1'b0;
    wait_idle;
    rd(OFS_ADDRH, q);
    check("addrh end", 32'h4, q);
    rd(OFS_ADDRL, q);
    check("addrl end", 32'h0, q);
    cpu_rd(15'h7FC, r);
    check("word lo", {14'h0, 2'b01, 16'h1234}, r);
    cpu_rd(15'h7FE, r);
    check("word hi", {14'h0, 2'b01, 16'h5678}, r);
    done("dma_write");
  endtask
  // Reprogram clears bits only; an odd last byte is dropped
  task test_clear_only;
    logic [31:0] q;
    logic [17:0] r;
    wr(OFS_ADDRH, 32'h3);
    wr(OFS_ADDRL, 32'hFE);
    wr(OFS_CTRL, 32'h2);
    m.wait_dma_trigger_select(10);
    m.put(8'hFF);
    m.wait_dma_trigger_select(10);
    m.put(8'hF0);
    m.wait_dma_trigger_select(1000);
    m.put(8'h00);
    wait_idle;
    rd(OFS_ADDRL, q);
    check("addrl fail", 32'hFF, q);
    cpu_rd(15'h7FC, r);
    check("cleared", {14'h0, 2'b01, 16'h1034}, r);
    cpu_rd(15'h7FE, r);
    check("half dropped", {14'h0, 2'b01, 16'h5678}, r);
    done("clear_only");
  endtask
  // Page erase picks the page from the high bits only
  task test_page_erase;
    logic [17:0] r;
    wr(OFS_ADDRH, 32'h3);
    wr(OFS_CTRL, 32'h1);
    cpu_rd(15'h7FC, r);
    check("stall", 32'h1, r[17]);
    wait_idle;
    cpu_rd(15'h7FC, r);
    check("erased top", {14'h0, 2'b01, ERASED_WORD}, r);
    cpu_rd(15'h400, r);
    check("erased base", {14'h0, 2'b01, ERASED_WORD}, r);
    done("page_erase");
  endtask
  // Whole erase with start: trigger only after the walk, then one word
  task test_chip_erase;
    logic [17:0] r;
    wr(OFS_ADDRH, 32'h0);
    wr(OFS_ADDRL, 32'h0);
    wr(OFS_CTRL, 32'h6);
    cpu_rd(15'h0000, r);
    check("chip stall", 32'h1, r[17]);
    check("chip no trigger", 32'h0, dma_trigger);
    m.wait_dma_trigger_select(20000);
    m.put(8'h0F);
    m.wait_dma_trigger_select(10);
    m.put(8'hA5);
    wait_idle;
    cpu_rd(15'h0000, r);
    check("chip first", {14'h0, 2'b01, 16'hA50F}, r);
    cpu_rd(15'h7FFE, r);
    check("chip last", {14'h0, 2'b01, ERASED_WORD}, r);
    done("chip_erase");
  endtask
  // Reset in mid sequence returns to idle with cleared registers
  task test_mid_reset;
    logic [31:0] q;
    wr(OFS_ADDRL, 32'h55);
    wr(OFS_CTRL, 32'h2);
    m.wait_dma_trigger_select(10);
    m.put(8'h11);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(OFS_CTRL, q);
    check("ctrl after reset", 32'h0, q);
    rd(OFS_ADDRL, q);
    check("addrl after reset", 32'h0, q);
    done("mid_reset");
  endtask

  // ====
  // Clock and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    failures = 0;
    comparisons = 0;
    resetn = 1'b0;
    cpu_req = 1'b0;
    cpu_addr = 15'h0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    test_reset;
    test_dma_write;
    test_clear_only;
    test_page_erase;
    test_chip_erase;
    test_mid_reset;
    stop_test;
  end
endmodule
